/* File: src/fsc_status_regs.sv */
`timescale 1ns/10ps
`include "fsc_regs.svh"
// Overview of operation
// - Status read accepted even while busy.
// - Status byte repeats until chip select rises.
// - Status read works up to 104 MHz.
// - Status byte field layout fixed.
// - Busy flag internal, set during operations.
// - Write latch set, cleared by commands, completion.
// - Latch low rejects writes, program, erase.
// - Register write clears write latch on completion.
// - Protect bits volatile or not, written by register write.
// - Protected area refuses program and erase.
// - Whole erase only with protect bits zero.
// - Protect bits default to zero.
// - Erase failure flag sticky until clear.
// - Program failure flag sticky until clear.
// - Protection refusals never set failure flags.
// - Lock bit plus pin low blocks register writes.
// - Config read any time, ships as zero.
// - Eight or sixteen data bits, else discarded.
// - Register write is self-timed, busy, then cleared.
// - Register write keeps busy, errors; reserved zero.
// - Register write works up to 104 MHz.
// - Lock left when pin goes high, or by a register write already under way.
// - Four-lane mode disables hardware lock.
module fsc_status_regs
    import fsc_pkg::*;
#(
    parameter int NUM_SECTORS  = 128,
    parameter int SECTOR_W     = 7,
    parameter int REGWR_CYCLES = `FSC_REGWR_CYCLES
) (
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                ce_i,
    input  wire logic                sclk_i,
    input  wire logic                cs_n_i,
    input  wire logic                mosi_i,
    input  wire logic                write_protect_accel_pin_i,
    output logic                     miso_o,
    output logic                     miso_oe_n_o,
    input  wire logic                pe_req_i,
    input  wire fsc_pe_kind_t        pe_kind_i,
    input  wire logic [SECTOR_W-1:0] pe_sector_i,
    input  wire logic                pe_done_i,
    input  wire logic                pe_fail_i,
    output logic                     pe_grant_o,
    output logic                     pe_refuse_o,
    output logic                     busy_flag_o,
    output logic                     write_latch_o,
    output logic                     hardware_lock_mode_o,
    output logic [2:0]               block_protect_o,
    output fsc_byte_t                config_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    fsc_state_t  state_q;
    logic        lock_q;
    logic        pfail_q;
    logic        efail_q;
    logic [2:0]  bp_nv_q;
    logic [2:0]  bp_vol_q;
    logic [2:0]  bp;
    logic        latch_q;
    fsc_byte_t   cfg_q;
    fsc_byte_t   pend_stat_q;
    fsc_byte_t   pend_cfg_q;
    logic        pend_both_q;
    logic        pe_erase_q;
    logic        busy;
    logic        hw_lock;
    fsc_byte_t   status;
    fsc_byte_t   shadow_stat_q;
    fsc_byte_t   shadow_cfg_q;
    logic        shadow_req_q;
    logic        ack_s1_q;
    logic        ack_s2_q;
    logic        cs_s1_q;
    logic        cs_s2_q;
    logic        cs_s3_q;
    logic        wp_s1_q;
    logic        wp_s2_q;
    logic        frame_end;
    fsc_byte_t   f_op;
    logic [15:0] f_data;
    logic [4:0]  f_bits;
    logic        f_long;
    logic        one_byte;
    logic        cmd_wr_en;
    logic        cmd_wr_dis;
    logic        cmd_clear;
    logic        regwr_go;
    logic        regwr_done;
    logic        pe_ok;
    logic        pe_erase_kind;
    logic        link_ack;

    // ------------------------------------------------------------
    // Protection region decode
    // ------------------------------------------------------------
    function automatic logic fsc_is_protected(input logic [2:0]          bp_f,
                                              input logic                top_f,
                                              input logic [SECTOR_W-1:0] sec_f);
        int size;
        size = NUM_SECTORS >> (7 - int'(bp_f));
        if (bp_f == 3'h0) begin
            return 1'b0;
        end
        if (top_f) begin
            return int'(sec_f) >= (NUM_SECTORS - size);
        end
        return int'(sec_f) < size;
    endfunction : fsc_is_protected

    // ------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------
    fsc_spi_link u_link (
        .sclk_i        (sclk_i),
        .cs_n_i        (cs_n_i),
        .sys_rst_i     (sys_rst_i),
        .mosi_i        (mosi_i),
        .miso_o        (miso_o),
        .miso_oe_n_o   (miso_oe_n_o),
        .shadow_stat_i (shadow_stat_q),
        .shadow_cfg_i  (shadow_cfg_q),
        .shadow_req_i  (shadow_req_q),
        .shadow_ack_o  (link_ack),
        .frame_op_o    (f_op),
        .frame_data_o  (f_data),
        .frame_bits_o  (f_bits),
        .frame_long_o  (f_long)
    );

    // ------------------------------------------------------------
    // Pin and crossing synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            cs_s3_q  <= 1'b1;
            wp_s1_q  <= 1'b1;
            wp_s2_q  <= 1'b1;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else if (ce_i) begin
            cs_s1_q  <= cs_n_i;
            cs_s2_q  <= cs_s1_q;
            cs_s3_q  <= cs_s2_q;
            wp_s1_q  <= write_protect_accel_pin_i;
            wp_s2_q  <= wp_s1_q;
            ack_s1_q <= link_ack;
            ack_s2_q <= ack_s1_q;
        end
    end

    // Link shifter is idle once chip select is seen high
    assign frame_end = ce_i & cs_s2_q & ~cs_s3_q;
    assign one_byte  = !f_long && (f_bits == `FSC_BITS_CMD);
    assign cmd_wr_en  = frame_end && one_byte && (f_op == `FSC_OP_WRITE_EN);
    assign cmd_wr_dis = frame_end && one_byte && (f_op == `FSC_OP_WRITE_DIS);
    assign cmd_clear = frame_end && one_byte && (f_op == `FSC_OP_CLEAR_STATUS);

    // ------------------------------------------------------------
    // Hardware lock
    // ------------------------------------------------------------
    // Lock bit changes while locked only by a register write already under way; otherwise only the pin releases it
    assign hw_lock = lock_q & ~wp_s2_q & ~cfg_q[`FSC_CF_QUAD_BIT];

    assign regwr_go = frame_end && (f_op == `FSC_OP_WRITE_REGS) && !f_long
                 && (f_bits == `FSC_BITS_ONE_BYTE || f_bits == `FSC_BITS_TWO_BYTES)
                 && latch_q
                 && (state_q == FSC_ST_IDLE)
                 && !hw_lock;

    assign bp = cfg_q[`FSC_CF_NVPROT_BIT] ? bp_nv_q : bp_vol_q;

    // ------------------------------------------------------------
    // Array operation gate
    // ------------------------------------------------------------
    assign pe_erase_kind = (pe_kind_i >= FSC_PE_P4);
    always_comb begin
        pe_ok = latch_q && (state_q == FSC_ST_IDLE);
        if (pe_kind_i == FSC_PE_BULK) begin
            pe_ok = pe_ok && (bp == 3'h0);
        end else begin
            pe_ok = pe_ok && !fsc_is_protected(bp, cfg_q[`FSC_CF_PROT_TOP_BIT], pe_sector_i);
        end
        if (pe_kind_i == FSC_PE_QUAD) begin
            pe_ok = pe_ok && cfg_q[`FSC_CF_QUAD_BIT];
        end
    end

    // ------------------------------------------------------------
    // Operation sequencer
    // ------------------------------------------------------------
    fsc_wcycle_timer #(
        .CYCLES (REGWR_CYCLES)
    ) u_timer (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .start_i   (regwr_go),
        .done_o    (regwr_done)
    );

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q     <= FSC_ST_IDLE;
            pe_grant_o  <= 1'b0;
            pe_refuse_o <= 1'b0;
            pe_erase_q  <= 1'b0;
        end else if (ce_i) begin
            pe_grant_o  <= 1'b0;
            pe_refuse_o <= 1'b0;
            case (state_q)
                FSC_ST_IDLE: begin
                    if (regwr_go) begin
                        state_q     <= FSC_ST_REGS;
                        pe_refuse_o <= pe_req_i;
                    end else if (pe_req_i) begin
                        pe_grant_o  <= pe_ok;
                        pe_refuse_o <= !pe_ok;
                        pe_erase_q  <= pe_erase_kind;
                        if (pe_ok) begin
                            state_q <= FSC_ST_ARRAY;
                        end
                    end
                end
                FSC_ST_REGS: begin
                    if (regwr_done) begin
                        state_q <= FSC_ST_IDLE;
                    end
                    if (pe_req_i) begin
                        pe_refuse_o <= 1'b1;
                    end
                end
                FSC_ST_ARRAY: begin
                    if (pe_done_i) begin
                        state_q <= FSC_ST_IDLE;
                    end
                    if (pe_req_i) begin
                        pe_refuse_o <= 1'b1;
                    end
                end
                default: begin
                    state_q <= FSC_ST_IDLE;
                end
            endcase
        end
    end

    assign busy = (state_q != FSC_ST_IDLE);

    // ------------------------------------------------------------
    // Write latch
    // ------------------------------------------------------------
    // Enable wins over a same-cycle completion
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            latch_q <= 1'b0;
        end else if (ce_i) begin
            if (cmd_wr_en) begin
                latch_q <= 1'b1;
            end else if (cmd_wr_dis || regwr_done || (state_q == FSC_ST_ARRAY && pe_done_i)) begin
                latch_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Failure flags
    // ------------------------------------------------------------
    // Only granted operations report done, so refusals never set these
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pfail_q <= 1'b0;
            efail_q <= 1'b0;
        end else if (ce_i) begin
            if (state_q == FSC_ST_ARRAY && pe_done_i && pe_fail_i && !pe_erase_q) begin
                pfail_q <= 1'b1;
            end else if (cmd_clear) begin
                pfail_q <= 1'b0;
            end
            if (state_q == FSC_ST_ARRAY && pe_done_i && pe_fail_i && pe_erase_q) begin
                efail_q <= 1'b1;
            end else if (cmd_clear) begin
                efail_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Register write capture and commit
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pend_stat_q <= 8'h00;
            pend_cfg_q  <= `FSC_CF_RESET;
            pend_both_q <= 1'b0;
        end else if (ce_i && regwr_go) begin
            pend_both_q <= (f_bits == `FSC_BITS_TWO_BYTES);
            pend_stat_q <= (f_bits == `FSC_BITS_TWO_BYTES) ? f_data[15:8] : f_data[7:0];
            pend_cfg_q  <= f_data[7:0];
        end
    end

    // New values take effect when the self-timed cycle ends
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lock_q   <= 1'b0;
            bp_nv_q  <= `FSC_BP_RESET;
            bp_vol_q <= `FSC_BP_RESET;
            cfg_q    <= `FSC_CF_RESET;
        end else if (ce_i && regwr_done) begin
            lock_q <= pend_stat_q[`FSC_ST_LOCK_BIT];
            if (cfg_q[`FSC_CF_NVPROT_BIT]) begin
                bp_nv_q <= pend_stat_q[`FSC_ST_BP_HI:`FSC_ST_BP_LO];
            end else begin
                bp_vol_q <= pend_stat_q[`FSC_ST_BP_HI:`FSC_ST_BP_LO];
            end
            if (pend_both_q) begin
                cfg_q <= pend_cfg_q & `FSC_CF_WMASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Status byte and its image for the link
    // ------------------------------------------------------------
    always_comb begin
        status                                   = 8'h00;
        status[`FSC_ST_LOCK_BIT]                 = lock_q;
        status[`FSC_ST_PFAIL_BIT]                = pfail_q;
        status[`FSC_ST_EFAIL_BIT]                = efail_q;
        status[`FSC_ST_BP_HI:`FSC_ST_BP_LO]      = bp;
        status[`FSC_ST_LATCH_BIT]                = latch_q;
        status[`FSC_ST_BUSY_BIT]                 = busy;
    end

    // A new image is offered only after the last one was taken
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            shadow_stat_q <= 8'h00;
            shadow_cfg_q  <= `FSC_CF_RESET;
            shadow_req_q  <= 1'b0;
        end else if (ce_i) begin
            if ((shadow_req_q == ack_s2_q) && ((status != shadow_stat_q) || (cfg_q != shadow_cfg_q))) begin
                shadow_stat_q <= status;
                shadow_cfg_q  <= cfg_q;
                shadow_req_q  <= ~shadow_req_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy_flag_o          = busy;
    assign write_latch_o        = latch_q;
    assign hardware_lock_mode_o = hw_lock;
    assign block_protect_o      = bp;
    assign config_o             = cfg_q;

endmodule : fsc_status_regs

/* File: src/fsc_regs.svh */
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH

// ------------------------------------------------------------
// Status byte fields
// ------------------------------------------------------------
`define FSC_ST_LOCK_BIT      7
`define FSC_ST_PFAIL_BIT     6
`define FSC_ST_EFAIL_BIT     5
`define FSC_ST_BP_HI         4
`define FSC_ST_BP_LO         2
`define FSC_ST_LATCH_BIT     1
`define FSC_ST_BUSY_BIT      0
`define FSC_BP_RESET         3'h0

// ------------------------------------------------------------
// Configuration byte fields
// ------------------------------------------------------------
`define FSC_CF_QUAD_BIT      1
`define FSC_CF_PARAM_TOP_BIT 2
`define FSC_CF_NVPROT_BIT    3
`define FSC_CF_PROT_TOP_BIT  5
`define FSC_CF_WMASK         8'h2e
`define FSC_CF_RESET         8'h00

// ------------------------------------------------------------
// Command opcodes
// ------------------------------------------------------------
`define FSC_OP_WRITE_REGS    8'h01
`define FSC_OP_WRITE_DIS     8'h04
`define FSC_OP_READ_STATUS   8'h05
`define FSC_OP_WRITE_EN      8'h06
`define FSC_OP_CLEAR_STATUS  8'h30
`define FSC_OP_READ_CONFIG   8'h35

// ------------------------------------------------------------
// Frame lengths in link clock edges
// ------------------------------------------------------------
`define FSC_BITS_CMD         5'd8
`define FSC_BITS_ONE_BYTE    5'd16
`define FSC_BITS_TWO_BYTES   5'd24

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define FSC_CLK_MHZ          20
`define FSC_REGWR_TIME_US    1000
`define FSC_REGWR_CYCLES     (`FSC_REGWR_TIME_US * `FSC_CLK_MHZ)

`endif

/* File: src/fsc_pkg.sv */
package fsc_pkg;

    // --------------------------------------------------------
    // Types
    // --------------------------------------------------------
    typedef logic [7:0] fsc_byte_t;

    typedef enum logic [1:0] {
        FSC_ST_IDLE  = 2'b00,
        FSC_ST_REGS  = 2'b01,
        FSC_ST_ARRAY = 2'b10
    } fsc_state_t;

    typedef enum logic [2:0] {
        FSC_PE_PAGE   = 3'h0,
        FSC_PE_QUAD   = 3'h1,
        FSC_PE_P4     = 3'h2,
        FSC_PE_P8     = 3'h3,
        FSC_PE_SECTOR = 3'h4,
        FSC_PE_BULK   = 3'h5
    } fsc_pe_kind_t;

endpackage : fsc_pkg

/* File: src/fsc_wcycle_timer.sv */
`timescale 1ns/10ps
module fsc_wcycle_timer #(
    parameter int CYCLES = 20000
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic ce_i,
    input  wire logic start_i,
    output logic      done_o
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_q;

    // ------------------------------------------------------------
    // Self-timed down counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q  <= '0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (start_i) begin
                cnt_q <= CW'(CYCLES);
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - CW'(1);
                if (cnt_q == CW'(1)) begin
                    done_o <= 1'b1;
                end
            end
        end
    end

endmodule : fsc_wcycle_timer

/* File: src/fsc_spi_link.sv */
`timescale 1ns/10ps
`include "fsc_regs.svh"
module fsc_spi_link
    import fsc_pkg::*;
(
    input  wire logic      sclk_i,
    input  wire logic      cs_n_i,
    input  wire logic      sys_rst_i,
    input  wire logic      mosi_i,
    output logic           miso_o,
    output logic           miso_oe_n_o,
    input  wire fsc_byte_t shadow_stat_i,
    input  wire fsc_byte_t shadow_cfg_i,
    input  wire logic      shadow_req_i,
    output logic           shadow_ack_o,
    output fsc_byte_t      frame_op_o,
    output logic [15:0]    frame_data_o,
    output logic [4:0]     frame_bits_o,
    output logic           frame_long_o
);
    logic        fresh_q;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_now;
    logic [23:0] sh_q;
    logic        req_s1_q;
    logic        req_s2_q;
    fsc_byte_t   stat_l_q;
    fsc_byte_t   cfg_l_q;
    logic        drv_q;
    logic [2:0]  idx;

    // ------------------------------------------------------------
    // Frame start marker, set while chip select is high
    // ------------------------------------------------------------
    always_ff @(posedge sclk_i or posedge cs_n_i or posedge sys_rst_i) begin
        if (sys_rst_i || cs_n_i) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    assign cnt_now = fresh_q ? 5'd0 : cnt_q;

    // ------------------------------------------------------------
    // Input shifter; results hold after the frame for the core
    // ------------------------------------------------------------
    always_ff @(posedge sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q        <= 5'd0;
            frame_long_o <= 1'b0;
            sh_q         <= 24'h0;
            frame_op_o   <= 8'h00;
        end else begin
            cnt_q        <= cnt_now + 5'd1;
            frame_long_o <= (fresh_q ? 1'b0 : frame_long_o) | (cnt_now >= `FSC_BITS_TWO_BYTES);
            sh_q         <= {sh_q[22:0], mosi_i};
            if (cnt_now == 5'd7) begin
                frame_op_o <= {sh_q[6:0], mosi_i};
            end
        end
    end

    assign frame_bits_o = cnt_q;
    assign frame_data_o = sh_q[15:0];

    // ------------------------------------------------------------
    // Register image handshake from the core
    // ------------------------------------------------------------
    always_ff @(posedge sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_s1_q     <= 1'b0;
            req_s2_q     <= 1'b0;
            shadow_ack_o <= 1'b0;
            stat_l_q     <= 8'h00;
            cfg_l_q      <= `FSC_CF_RESET;
        end else begin
            req_s1_q <= shadow_req_i;
            req_s2_q <= req_s1_q;
            if (req_s2_q != shadow_ack_o) begin
                stat_l_q     <= shadow_stat_i;
                cfg_l_q      <= shadow_cfg_i;
                shadow_ack_o <= req_s2_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Output on falling edge; reads wrap on the byte
    // ------------------------------------------------------------
    assign idx = 3'd7 - cnt_q[2:0];

    always_ff @(negedge sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            miso_o <= 1'b0;
            drv_q  <= 1'b0;
        end else begin
            drv_q  <= 1'b0;
            miso_o <= 1'b0;
            if (!fresh_q && (frame_long_o || cnt_q >= `FSC_BITS_CMD)) begin
                if (frame_op_o == `FSC_OP_READ_STATUS) begin
                    drv_q  <= 1'b1;
                    miso_o <= stat_l_q[idx];
                end else if (frame_op_o == `FSC_OP_READ_CONFIG) begin
                    drv_q  <= 1'b1;
                    miso_o <= cfg_l_q[idx];
                end
            end
        end
    end

    assign miso_oe_n_o = cs_n_i | ~drv_q;

endmodule : fsc_spi_link

/* File: tb/fsc_status_regs_chk.sv */
`timescale 1ns/10ps
module fsc_status_regs_chk
    import fsc_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         sys_rst_i,
    input wire logic         ce_i,
    input wire logic         cs_n_i,
    input wire logic         pe_req_i,
    input wire fsc_pe_kind_t pe_kind_i,
    input wire logic         pe_done_i,
    input wire logic         pe_grant_o,
    input wire logic         pe_refuse_o,
    input wire logic         busy_flag_o,
    input wire logic         write_latch_o,
    input wire logic         hardware_lock_mode_o,
    input wire logic [2:0]   block_protect_o,
    input wire fsc_byte_t    config_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic rq = pe_req_i & ce_i;
    no_latch_a: assert property (rq && !write_latch_o |=> pe_refuse_o) else $error("latch low");
    busy_refuse_a: assert property (rq && busy_flag_o |=> pe_refuse_o) else $error("busy");
    bulk_guard_a: assert property (rq && pe_kind_i == FSC_PE_BULK && block_protect_o != 3'h0
        |=> pe_refuse_o) else $error("bulk");
    grant_busy_a: assert property (pe_grant_o |-> busy_flag_o) else $error("grant idle");
    done_clear_a: assert property (busy_flag_o && pe_done_i && ce_i
        |=> !busy_flag_o && !write_latch_o) else $error("done");
    cfg_commit_a: assert property ($changed(config_o) |-> $fell(busy_flag_o)) else $error("cfg");
    bp_commit_a: assert property ($changed(block_protect_o) |-> $fell(busy_flag_o)) else $error("bp");
    latch_rise_a: assert property ($rose(write_latch_o) |-> cs_n_i) else $error("latch");
    quad_lock_a: assert property (hardware_lock_mode_o |-> !config_o[1]) else $error("quad");
    cover property (pe_grant_o);
    cover property ($fell(busy_flag_o));
    cover property (hardware_lock_mode_o);
endmodule : fsc_status_regs_chk

/* File: tb/fsc_host_model.sv */
`timescale 1ns/10ps
module fsc_host_model
    import fsc_pkg::*;
(
    input  wire logic miso_i,
    output logic      sclk_o = 1'b0,
    output logic      cs_n_o = 1'b1,
    output logic      mosi_o = 1'b0
);
    // Clock stands low between frames; 160 ns period, well under the rate ceiling
    task automatic xfer(input logic [23:0] d, input int n, output fsc_byte_t r);
        #13 cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            #40 mosi_o = d[23-i];
            #40 sclk_o = 1'b1;
            r = {r[6:0], miso_i};
            #80 sclk_o = 1'b0;
        end
        #40 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #400;
    endtask : xfer
endmodule : fsc_host_model

/* File: tb/fsc_status_regs_tb.sv */
`timescale 1ns/10ps
module fsc_status_regs_tb
    import fsc_pkg::*;
;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, req = 1'b0, done = 1'b0, fail = 1'b0, wp = 1'b1;
    logic sclk, cs_n, mosi, miso, oe_n, grant, refuse, busy, latch, lock;
    logic [6:0] sec = 7'h0;
    logic [2:0] bp;
    fsc_pe_kind_t kind = FSC_PE_PAGE;
    fsc_byte_t cfg, r;
    int failures = 0, checked = 0;
    always #25 clk_i = ~clk_i;
    fsc_status_regs #(.REGWR_CYCLES(200)) fsc_status_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .write_protect_accel_pin_i(wp),
        .miso_o(miso), .miso_oe_n_o(oe_n), .pe_req_i(req), .pe_kind_i(kind), .pe_sector_i(sec),
        .pe_done_i(done), .pe_fail_i(fail), .pe_grant_o(grant), .pe_refuse_o(refuse), .busy_flag_o(busy),
        .write_latch_o(latch), .hardware_lock_mode_o(lock), .block_protect_o(bp), .config_o(cfg));
    fsc_host_model fsc_host_model_inst (.miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
    task automatic chk(input fsc_byte_t s, e);
        checked++;
        if (s !== e) failures++;
        if (s !== e) $display("ERROR %0t seen %h exp %h", $time, s, e);
    endtask : chk
    task automatic op(input logic [23:0] d, input int n);
        fsc_host_model_inst.xfer(d, n, r);
    endtask : op
    // Third byte of the frame is judged; the second may lag a change
    task automatic rd(input fsc_byte_t c, e);
        fsc_host_model_inst.xfer({c, 16'h0}, 24, r);
        chk(r, e);
    endtask : rd
    task automatic pe(input fsc_pe_kind_t k, input logic [6:0] s, input logic f, g);
        @(posedge clk_i) #1 {req, sec, fail} = {1'b1, s, f};
        kind = k;
        @(posedge clk_i) #1 req = 1'b0;
        chk({6'h0, grant, refuse}, {6'h0, g, !g});
        repeat (3) @(posedge clk_i);
        #1 done = g;
        @(posedge clk_i) #1 done = 1'b0;
    endtask : pe
    task automatic wb;
        for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk({7'h0, busy}, 8'h00);
    endtask : wb
    task automatic s_latch;
        chk({7'h0, oe_n}, 8'h01);
        rd(8'h05, 8'h00);
        rd(8'h35, 8'h00);
        pe(FSC_PE_PAGE, 7'h0, 1'b0, 1'b0);
        op(24'h060000, 8);
        chk({7'h0, latch}, 8'h01);
        rd(8'h05, 8'h02);
        op(24'h040000, 8);
        rd(8'h05, 8'h00);
        op(24'h060000, 8);
        pe(FSC_PE_SECTOR, 7'h3, 1'b1, 1'b1);
        rd(8'h05, 8'h20);
    endtask : s_latch
    task automatic s_write;
        op(24'h060000, 8);
        op(24'h011e00, 16);
        rd(8'h05, 8'h23);
        wb;
        rd(8'h05, 8'h3c);
        chk({5'h0, bp}, 8'h07);
    endtask : s_write
    task automatic s_guard;
        op(24'h060000, 8);
        pe(FSC_PE_BULK, 7'h0, 1'b0, 1'b0);
        pe(FSC_PE_PAGE, 7'h5, 1'b0, 1'b0);
        op(24'h01f000, 12);
        rd(8'h05, 8'h3e);
        op(24'h018028, 24);
        wb;
        rd(8'h05, 8'ha0);
        rd(8'h35, 8'h28);
        chk(cfg, 8'h28);
    endtask : s_guard
    task automatic s_lock;
        @(posedge clk_i) #1 wp = 1'b0;
        repeat (4) @(posedge clk_i);
        chk({7'h0, lock}, 8'h01);
        op(24'h060000, 8);
        op(24'h010000, 16);
        rd(8'h05, 8'ha2);
        @(posedge clk_i) #1 wp = 1'b1;
        repeat (4) @(posedge clk_i);
        chk({7'h0, lock}, 8'h00);
        op(24'h300000, 8);
        rd(8'h05, 8'h82);
    endtask : s_lock
    task automatic end_of_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial begin
        #500000 failures++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        s_latch;
        s_write;
        s_guard;
        s_lock;
        end_of_test;
    end
endmodule : fsc_status_regs_tb
bind fsc_status_regs fsc_status_regs_chk fsc_status_regs_chk_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce_i), .cs_n_i(cs_n_i), .pe_req_i(pe_req_i), .pe_kind_i(pe_kind_i), .pe_done_i(pe_done_i),
    .pe_grant_o(pe_grant_o), .pe_refuse_o(pe_refuse_o), .busy_flag_o(busy_flag_o),
    .write_latch_o(write_latch_o), .hardware_lock_mode_o(hardware_lock_mode_o),
    .block_protect_o(block_protect_o), .config_o(config_o));
